/* hdl/lhp_pkg.sv */
package lhp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and pin timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETUP_NS      = 50;
  localparam int STROBE_NS     = 250;
  localparam int HOLD_NS       = 50;
  localparam int CLEAR_NS      = 1000;

  // Least times round up, never below one cycle
  function automatic int ns_to_min_cyc(input int ns);
    int cyc;
    cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc;
  endfunction

  localparam int SETUP_CYC  = ns_to_min_cyc(SETUP_NS);
  localparam int STROBE_CYC = ns_to_min_cyc(STROBE_NS);
  localparam int HOLD_CYC   = ns_to_min_cyc(HOLD_NS);
  localparam int CLEAR_CYC  = ns_to_min_cyc(CLEAR_NS);
  localparam int CNT_W      = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and encodings
  localparam logic       STYLE_6800  = 1'b0;
  localparam logic       STYLE_8080  = 1'b1;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

  typedef struct packed {
    logic       is_read;
    logic       register_select;
    logic [7:0] data;
  } lhp_req_type;

  typedef enum logic [2:0] {
    LHP_CLEAR,
    LHP_IDLE,
    LHP_SETUP,
    LHP_STROBE,
    LHP_HOLD
  } lhp_state_type;

endpackage

/* hdl/lhp_sync2.sv */
`timescale 1ns/1ps
module lhp_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // First stage feeds only the second stage
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

/* hdl/lhp_host_port.sv */
`timescale 1ns/1ps
// How it works
// - In 6800 style, the enable strobe goes high only to read or write.
// - Chip select is low around every strobe; register_select and db_out take the new request one cycle before it falls.
// - module_clear_n is driven low after reset and on clear request.
// - A busy wait input stretches the strobe until the module is free.
module lhp_host_port #(
  parameter int SETUP_CYC  = lhp_pkg::SETUP_CYC,
  parameter int STROBE_CYC = lhp_pkg::STROBE_CYC,
  parameter int HOLD_CYC   = lhp_pkg::HOLD_CYC,
  parameter int CLEAR_CYC  = lhp_pkg::CLEAR_CYC
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               req_valid,
  input  lhp_pkg::lhp_req_type    req,
  output logic                    req_ready,
  output logic                    rsp_valid,
  output logic [7:0]              rsp_data,
  input  wire logic               clear_req,
  input  wire logic               blank_req,
  output logic                    style_8080,
  output logic                    lcd_cs_n,
  output logic                    lcd_strobe,
  output logic                    lcd_dir,
  output logic                    register_select,
  output logic [7:0]              db_out,
  output logic                    db_oe,
  input  wire logic [7:0]         db_in,
  output logic                    module_clear_n,
  output logic                    panel_blank_n,
  input  wire logic               busy_wait,
  input  wire logic               bus_style_strap
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [9:0] pins_sync;
  logic [7:0] db_sync;
  logic       busy_sync;
  logic       strap_sync;

  lhp_sync2 #(
    .WIDTH (10)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({bus_style_strap, busy_wait, db_in}),
    .sync_out (pins_sync)
  );

  assign db_sync    = pins_sync[7:0];
  assign busy_sync  = pins_sync[8];
  assign strap_sync = pins_sync[9];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  lhp_pkg::lhp_state_type     state;
  lhp_pkg::lhp_req_type       cur;
  logic [lhp_pkg::CNT_W-1:0]  cnt;
  logic                       strobe_on;
  logic                       access_on;
  logic                       clear_on;

  localparam logic [lhp_pkg::CNT_W-1:0] SETUP_LAST  = lhp_pkg::CNT_W'(SETUP_CYC - 1);
  localparam logic [lhp_pkg::CNT_W-1:0] STROBE_LAST = lhp_pkg::CNT_W'(STROBE_CYC - 1);
  localparam logic [lhp_pkg::CNT_W-1:0] HOLD_LAST   = lhp_pkg::CNT_W'(HOLD_CYC - 1);
  localparam logic [lhp_pkg::CNT_W-1:0] CLEAR_LAST  = lhp_pkg::CNT_W'(CLEAR_CYC - 1);

  // New requests wait while a clear is pending
  assign req_ready = (state == lhp_pkg::LHP_IDLE) && !clear_req;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= lhp_pkg::LHP_CLEAR;
      cnt   <= lhp_pkg::CNT_RESET;
    end else begin
      unique case (state)
        lhp_pkg::LHP_CLEAR: begin
          cnt <= cnt + 1'b1;
          if (cnt == CLEAR_LAST) begin
            state <= lhp_pkg::LHP_IDLE;
            cnt   <= lhp_pkg::CNT_RESET;
          end
        end
        lhp_pkg::LHP_IDLE: begin
          cnt <= lhp_pkg::CNT_RESET;
          if (clear_req) begin
            state <= lhp_pkg::LHP_CLEAR;
          end else if (req_valid) begin
            state <= lhp_pkg::LHP_SETUP;
          end
        end
        lhp_pkg::LHP_SETUP: begin
          cnt <= cnt + 1'b1;
          if (cnt == SETUP_LAST) begin
            state <= lhp_pkg::LHP_STROBE;
            cnt   <= lhp_pkg::CNT_RESET;
          end
        end
        lhp_pkg::LHP_STROBE: begin
          if (cnt != STROBE_LAST) begin
            cnt <= cnt + 1'b1;
          end else if (!busy_sync) begin
            state <= lhp_pkg::LHP_HOLD;
            cnt   <= lhp_pkg::CNT_RESET;
          end
        end
        lhp_pkg::LHP_HOLD: begin
          cnt <= cnt + 1'b1;
          if (cnt == HOLD_LAST) begin
            state <= lhp_pkg::LHP_IDLE;
            cnt   <= lhp_pkg::CNT_RESET;
          end
        end
      endcase
    end
  end

  // Request held for the whole access
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else if (req_ready && req_valid) begin
      cur <= req;
    end
  end

  // Strap caught after release, once the synchroniser has settled
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      style_8080 <= lhp_pkg::STYLE_6800;
    end else if (state == lhp_pkg::LHP_CLEAR && cnt == CLEAR_LAST) begin
      style_8080 <= strap_sync;
    end
  end

  // Read data taken while the strobe is still active
  // Pin lag plus synchroniser: strobe needs five cycles or more for valid data and busy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= lhp_pkg::DATA_RESET;
    end else begin
      rsp_valid <= 1'b0;
      if (state == lhp_pkg::LHP_STROBE && cnt == STROBE_LAST && !busy_sync && cur.is_read) begin
        rsp_valid <= 1'b1;
        rsp_data  <= db_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so strobes never glitch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      strobe_on <= 1'b0;
      access_on <= 1'b0;
      clear_on  <= 1'b1;
    end else begin
      strobe_on <= (state == lhp_pkg::LHP_STROBE);
      access_on <= (state == lhp_pkg::LHP_SETUP) || (state == lhp_pkg::LHP_STROBE) ||
                   (state == lhp_pkg::LHP_HOLD);
      clear_on  <= (state == lhp_pkg::LHP_CLEAR);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lcd_cs_n        <= 1'b1;
      lcd_strobe      <= 1'b0;
      lcd_dir         <= 1'b1;
      register_select <= 1'b0;
      db_out          <= lhp_pkg::DATA_RESET;
      db_oe           <= 1'b0;
      module_clear_n  <= 1'b0;
      panel_blank_n   <= 1'b0;
    end else begin
      lcd_cs_n        <= !access_on;
      register_select <= cur.register_select;
      db_out          <= cur.data;
      db_oe           <= access_on && !cur.is_read;
      module_clear_n  <= !clear_on;
      panel_blank_n   <= !blank_req;
      if (style_8080) begin
        lcd_strobe <= !(strobe_on && cur.is_read);
        lcd_dir    <= !(strobe_on && !cur.is_read);
      end else begin
        lcd_strobe <= strobe_on;
        lcd_dir    <= access_on ? cur.is_read : 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic strobe_pin_on;
  logic pin_style;

  // Style that produced the pins now showing, one cycle behind style_8080
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_style <= lhp_pkg::STYLE_6800;
    end else begin
      pin_style <= style_8080;
    end
  end

  assign strobe_pin_on = pin_style ? (!lcd_strobe || !lcd_dir) : lcd_strobe;

  sequence s_strobe_open;
    $rose(strobe_pin_on);
  endsequence

  sequence s_busy_seen;
    strobe_pin_on && busy_sync;
  endsequence

  property p_cs_covers_strobe;
    @(posedge core_clk) disable iff (sys_rst) strobe_pin_on |-> !lcd_cs_n;
  endproperty

  property p_cs_leads_strobe;
    @(posedge core_clk) disable iff (sys_rst) s_strobe_open |-> $past(!lcd_cs_n);
  endproperty

  property p_busy_stretch;
    @(posedge core_clk) disable iff (sys_rst) s_busy_seen |=> strobe_pin_on;
  endproperty

  AST_E_ONLY_IN_ACCESS: assert property (p_cs_covers_strobe)
    else $error("strobe active without chip select");
  AST_CS_BEFORE_STROBE: assert property (p_cs_leads_strobe)
    else $error("strobe rose in same cycle as chip select");
  AST_BUSY_EXTENDS: assert property (p_busy_stretch)
    else $error("strobe ended while module busy");
  AST_WRITE_DRIVES: assert property (@(posedge core_clk) disable iff (sys_rst)
    (strobe_pin_on && !cur.is_read) |-> (db_oe && db_out == cur.data &&
    register_select == cur.register_select))
    else $error("write strobe without stable data or select");
  AST_READ_NO_DRIVE: assert property (@(posedge core_clk) disable iff (sys_rst)
    (access_on && cur.is_read) |-> ##1 !db_oe)
    else $error("host drives data bus during read");
  AST_CLEAR_AFTER_RESET: assert property (@(posedge core_clk)
    $fell(sys_rst) |=> !module_clear_n [*2])
    else $error("module clear not driven after reset");
  AST_STRAP_STABLE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$stable(style_8080) |-> ($past(state) == lhp_pkg::LHP_CLEAR))
    else $error("bus style changed outside clear");
  AST_8080_IDLE_HIGH: assert property (@(posedge core_clk) disable iff (sys_rst)
    (style_8080 && $past(style_8080) && lcd_cs_n) |-> (lcd_strobe && lcd_dir))
    else $error("8080 strobes not idle high");
  AST_STROBE_MIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_strobe_open |-> strobe_pin_on [*2])
    else $error("strobe shorter than two cycles");

endmodule

/* testbench/lhp_lcd_model.sv */
`timescale 1ns/1ps
module lhp_lcd_model #(
  parameter logic [7:0] STATUS   = 8'hA5,
  parameter int         BUSY_CYC = 8
) (
  input  wire logic       core_clk,
  input  wire logic       lcd_cs_n,
  input  wire logic       lcd_strobe,
  input  wire logic       lcd_dir,
  input  wire logic       register_select,
  input  wire logic [7:0] db_out,
  input  wire logic       db_oe,
  input  wire logic       module_clear_n,
  input  wire logic       bus_style_strap,
  input  wire logic       slow,
  output logic      [7:0] db_in,
  output logic            busy_wait,
  output logic      [7:0] proto_err
);
  logic [7:0] err_cnt  = 8'h00;
  logic       rd_act;
  logic       wr_act;
  logic       cs_q     = 1'b1;
  logic [7:0] data_mem = 8'h00;
  logic [7:0] last_bus = 8'h00;
  logic [7:0] busy_cnt = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Strap picks strobe meaning; nothing moves without chip select
  assign rd_act = !lcd_cs_n &&
                  (bus_style_strap ? !lcd_strobe : lcd_strobe && lcd_dir);
  assign wr_act = !lcd_cs_n &&
                  (bus_style_strap ? !lcd_dir : lcd_strobe && !lcd_dir);
  assign proto_err = err_cnt;
  // Released bus shows the inverse, so a stale byte never passes
  assign db_in = rd_act ? (register_select ? STATUS : data_mem) : ~last_bus;
  assign busy_wait = busy_cnt != 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cs_q <= lcd_cs_n;
    if (rd_act) begin
      last_bus <= db_in;
    end
    if (wr_act && !register_select) begin
      data_mem <= db_out;
    end
    if ((wr_act && !db_oe) || (rd_act && db_oe) || (rd_act && wr_act)) begin
      err_cnt <= err_cnt + 8'h01;
    end
    if (slow && cs_q && !lcd_cs_n) begin
      busy_cnt <= 8'(BUSY_CYC);
    end else if (busy_cnt != 8'h00) begin
      busy_cnt <= busy_cnt - 8'h01;
    end
    if (!module_clear_n) begin
      data_mem <= 8'h00;
      busy_cnt <= 8'h00;
    end
  end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic       rd;
    logic       rs;
    logic [7:0] d;
    logic [7:0] exp;
  } lhp_row_type;
  localparam logic [7:0] STATUS_BYTE = 8'hA5;
  localparam lhp_row_type ROWS [0:5] = '{'{1'b0, 1'b1, 8'h5A, 8'h00},
    '{1'b0, 1'b0, 8'hC3, 8'h00}, '{1'b1, 1'b0, 8'h00, 8'hC3},
    '{1'b1, 1'b1, 8'h00, STATUS_BYTE}, '{1'b0, 1'b0, 8'h0F, 8'h00},
    '{1'b1, 1'b0, 8'h00, 8'h0F}};
  logic core_clk, sys_rst, req_valid, req_ready, rsp_valid, clear_req, blank_req;
  logic style_8080, lcd_cs_n, lcd_strobe, lcd_dir, register_select, db_oe;
  logic module_clear_n, panel_blank_n, busy_wait, bus_style_strap, slow;
  logic [7:0] rsp_data, db_out, db_in, proto_err;
  lhp_pkg::lhp_req_type req;
  int errors, total_checks, len, fast_len, slow_len, n;
  lhp_host_port #(.SETUP_CYC(1), .STROBE_CYC(5), .HOLD_CYC(1), .CLEAR_CYC(4)) lhp_host_port_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .clear_req(clear_req), .blank_req(blank_req), .style_8080(style_8080),
    .lcd_cs_n(lcd_cs_n), .lcd_strobe(lcd_strobe), .lcd_dir(lcd_dir),
    .register_select(register_select), .db_out(db_out), .db_oe(db_oe), .db_in(db_in),
    .module_clear_n(module_clear_n), .panel_blank_n(panel_blank_n),
    .busy_wait(busy_wait), .bus_style_strap(bus_style_strap));
  lhp_lcd_model #(.STATUS(STATUS_BYTE), .BUSY_CYC(8)) lhp_lcd_model_i (
    .core_clk(core_clk), .lcd_cs_n(lcd_cs_n), .lcd_strobe(lcd_strobe), .lcd_dir(lcd_dir),
    .register_select(register_select), .db_out(db_out), .db_oe(db_oe),
    .module_clear_n(module_clear_n), .bus_style_strap(bus_style_strap), .slow(slow),
    .db_in(db_in), .busy_wait(busy_wait), .proto_err(proto_err));
  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic give_up(input int k);
    if (k >= 500) begin
      errors++;
      end_sim();
    end
  endtask
  // One access; length runs from take to ready again
  task automatic xfer(input lhp_row_type r, output int cyc);
    int         k;
    logic       seen;
    logic [7:0] got;
    k = 0;
    seen = 1'b0;
    got = 8'h00;
    cyc = 0;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= {r.rd, r.rs, r.d};
    @(negedge core_clk);
    while (req_ready !== 1'b1 && k < 500) begin
      @(negedge core_clk);
      k++;
    end
    give_up(k);
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(negedge core_clk);
    while (req_ready !== 1'b1 && cyc < 500) begin
      if (rsp_valid === 1'b1) begin
        seen = 1'b1;
        got = rsp_data;
      end
      @(negedge core_clk);
      cyc++;
    end
    give_up(cyc);
    if (r.rd) begin
      chk1(seen, 1'b1);
      chk8(got, r.exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    clear_req = 1'b0;
    blank_req = 1'b0;
    bus_style_strap = 1'b0;
    slow = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (20) @(negedge core_clk);
    chk1(lcd_cs_n, 1'b1);
    chk1(module_clear_n, 1'b0);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (ROWS[i]) xfer(ROWS[i], len);
    chk1(style_8080, 1'b0);
    xfer(ROWS[1], fast_len);
    @(posedge core_clk);
    slow <= 1'b1;
    xfer(ROWS[1], slow_len);
    xfer(ROWS[2], len);
    chk1(slow_len > fast_len, 1'b1);
    @(posedge core_clk);
    slow <= 1'b0;
    blank_req <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk1(panel_blank_n, 1'b0);
    // Strap is only read during a clear, so it moves first
    @(posedge core_clk);
    bus_style_strap <= 1'b1;
    clear_req <= 1'b1;
    n = 0;
    @(negedge core_clk);
    while (module_clear_n !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    give_up(n);
    @(posedge core_clk);
    clear_req <= 1'b0;
    blank_req <= 1'b0;
    xfer('{1'b1, 1'b0, 8'h00, 8'h00}, len);
    chk1(style_8080, 1'b1);
    chk1(panel_blank_n, 1'b1);
    foreach (ROWS[i]) xfer(ROWS[i], len);
    chk8(proto_err, 8'h00);
    end_sim();
  end
endmodule
